/* rtl/relay_diag_pkg.sv */
// constants and types shared by the relay diagnosis register block
// assumes a single 50 MHz device clock; frame-level register port
package relay_diag_pkg;

    localparam int unsigned NUM_CHANNELS       = 8;          // switched channels
    localparam int unsigned REG_WIDTH          = 4;          // data bits per register

    // register bank selector values
    localparam logic        BANK_COMMAND       = 1'b0;       // bank holding the command register
    localparam logic        BANK_DIAG          = 1'b1;       // bank holding the diagnosis registers

    // register addresses inside a bank
    localparam logic [1:0]  ADDR_DIAG_0_1      = 2'h0;       // diag_channels_0_1
    localparam logic [1:0]  ADDR_DIAG_2_3      = 2'h1;       // diag_channels_2_3
    localparam logic [1:0]  ADDR_DIAG_4_5      = 2'h2;       // diag_channels_4_5
    localparam logic [1:0]  ADDR_DIAG_6_7      = 2'h3;       // diag_channels_6_7
    localparam logic [1:0]  ADDR_COMMAND       = 2'h0;       // command_control in command bank

    // field positions inside a diagnosis register
    localparam int unsigned LOW_FAULT_BIT      = 0;          // channel_fault_flag of low channel
    localparam int unsigned LOW_OPEN_BIT       = 1;          // open_load_flag of low channel
    localparam int unsigned HIGH_FAULT_BIT     = 2;          // channel_fault_flag of high channel
    localparam int unsigned HIGH_OPEN_BIT      = 3;          // open_load_flag of high channel

    // field positions inside the command register
    localparam int unsigned CMD_CLEAR_BIT      = 0;          // clear_fault_latches
    localparam int unsigned CMD_RESET_BIT      = 1;          // soft reset request
    localparam int unsigned CMD_STANDBY_BIT    = 2;          // standby_request
    localparam int unsigned CMD_WAKE_BIT       = 3;          // wake request

    // values after reset
    localparam logic [3:0]  CMD_RESET_VALUE    = 4'h0;       // command register
    localparam logic [7:0]  FLAGS_RESET_VALUE  = 8'h00;      // latched flags
    localparam logic [3:0]  RDATA_RESET_VALUE  = 4'h0;       // read data

    // overload shutdown timing
    localparam int unsigned CLK_FREQ_MHZ       = 50;         // device clock rate
    localparam int unsigned OVL_OFF_TIME_US    = 60;         // longest overload shut-down delay
    localparam int unsigned OVL_OFF_CYCLES     = OVL_OFF_TIME_US * CLK_FREQ_MHZ;  // exact product, 3000
    localparam int unsigned OVL_CNT_WIDTH      = 12;         // counter width covering the delay
    localparam logic [11:0] OVL_TRIP_COUNT     = 12'(OVL_OFF_CYCLES - 1);
    localparam logic [11:0] OVL_CNT_RESET      = 12'h000;    // counter value after reset

    typedef logic [NUM_CHANNELS-1:0] chan_t;     // one bit per channel
    typedef logic [REG_WIDTH-1:0]    reg_data_t; // register data word
    typedef logic [1:0]              reg_addr_t; // address inside a bank

endpackage : relay_diag_pkg

/* rtl/ovl_shutdown_if.sv */
// carrier between the register block and its overload shutdown timers
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface ovl_shutdown_if;
    import relay_diag_pkg::*;
    logic  clk_en;    // global clock enable
    chan_t overload;  // raw overload detector per channel
    chan_t tripped;   // high while the overload has lasted the full shutdown delay

    modport timer (input clk_en, input overload, output tripped);
    modport owner (output clk_en, output overload, input tripped);
endinterface : ovl_shutdown_if

/* rtl/ovl_shutdown_timer.sv */
// per-channel overload persistence timers
// assumes overload inputs are synchronous to clk_i
`timescale 1ns/1ps
module ovl_shutdown_timer
(
    input  wire logic     clk_i,   // device clock
    input  wire logic     rstn_i,  // asynchronous reset, active low
    ovl_shutdown_if.timer ovl      // overload in, trip out
);
    import relay_diag_pkg::*;

    // one running count per channel
    typedef struct packed {
        logic [NUM_CHANNELS-1:0][OVL_CNT_WIDTH-1:0] count;
    } timer_state_t;

    timer_state_t state_reg;   // registered state
    timer_state_t state_next;  // next state

    // trip as the count reaches its last cycle while the overload persists
    always_comb
    begin
        for (int n = 0; n < NUM_CHANNELS; n++)
        begin
            ovl.tripped[n] = ovl.overload[n] && (state_reg.count[n] == OVL_TRIP_COUNT);
        end
    end

    // count up while overloaded, restart as soon as the overload goes away
    always_comb
    begin
        state_next = state_reg;
        for (int n = 0; n < NUM_CHANNELS; n++)
        begin
            if (!ovl.overload[n])
            begin
                // condition gone: restart the delay
                state_next.count[n] = OVL_CNT_RESET;
            end
            else if (state_reg.count[n] != OVL_TRIP_COUNT)
            begin
                // still inside the delay window
                state_next.count[n] = state_reg.count[n] + 12'h001;
            end
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_reg <= '0;
        end
        else if (ovl.clk_en)
        begin
            state_reg <= state_next;
        end
    end

endmodule : ovl_shutdown_timer

/* rtl/relay_diag_status_regs.sv */
// diagnosis flag latching and register set of an eight-channel relay switch
// assumes a frame-level register port: one reg_valid_i strobe per valid serial frame
// assumes detector inputs arrive filtered and synchronous to clk_i
// assumes clk_en_i gates every flop here, the overload timers included
//
// What this block does
// - diagnosis registers read-only, bank one only
// - pair per register, fault even, open-load odd
// - fault flag set on overload/overtemp shutdown
// - open-load flag set on open load while off
// - command register: clear, reset, standby, wake bits
// - overload shuts channel off within 60 us
// - clear bit clears faults, self-clears next frame
// - reading diagnosis register clears its open-load flags
`timescale 1ns/1ps
module relay_diag_status_regs
(
    input  wire logic                    clk_i,            // device clock, 50 MHz
    input  wire logic                    rstn_i,           // asynchronous reset, active low
    input  wire logic                    clk_en_i,         // clock enable, freezes all state when low
    // register port
    input  wire logic                    reg_valid_i,      // one-cycle strobe per valid frame
    input  wire logic                    reg_write_i,      // frame is a write
    input  wire logic                    reg_bank_i,       // register_bank_selector
    input  wire relay_diag_pkg::reg_addr_t reg_addr_i,     // address inside the bank
    input  wire relay_diag_pkg::reg_data_t reg_wdata_i,    // write data
    output logic [3:0]                   reg_rdata_o,      // read data of the last read frame
    // channel side
    input  wire relay_diag_pkg::chan_t   channel_on_i,     // requested channel state
    input  wire relay_diag_pkg::chan_t   overload_i,       // overload detector per channel
    input  wire relay_diag_pkg::chan_t   overtemp_i,       // overtemperature detector per channel
    input  wire relay_diag_pkg::chan_t   open_load_i,      // off-state open load detector
    output relay_diag_pkg::chan_t        channel_enable_o, // gated channel drive
    output relay_diag_pkg::chan_t        channel_fault_flag_o, // latched fault flags
    output relay_diag_pkg::chan_t        open_load_flag_o,     // latched open-load flags
    output logic                         soft_reset_req_o,     // command register reset bit
    output logic                         standby_request_o,    // command register standby bit
    output logic                         wake_request_o        // command register wake bit
);
    import relay_diag_pkg::*;

    // all block state
    typedef struct packed {
        chan_t     fault;   // channel_fault_flag latches
        chan_t     open;    // open_load_flag latches
        reg_data_t cmd;     // command_control
        reg_data_t rdata;   // read data holding register
    } regs_state_t;

    regs_state_t state_reg;   // registered state
    regs_state_t state_next;  // next state

    // decoded frame
    logic        diag_read;   // valid read of a diagnosis register
    logic        cmd_write;   // valid write of the command register
    logic        cmd_read;    // valid read of the command register
    logic        clear_req;   // write that sets clear_fault_latches
    chan_t       fault_set;   // fault events this cycle
    chan_t       open_set;    // open-load events this cycle
    chan_t       open_clr;    // open-load flags read this cycle
    logic [1:0]  pair_sel;    // selected channel pair

    // connection to the overload timers
    ovl_shutdown_if ovl ();

    // true when the frame addresses a diagnosis register
    function automatic logic is_diag(input logic bank, input reg_addr_t addr);
        // every address in the diagnosis bank is mapped
        is_diag = (bank == BANK_DIAG) && (addr <= ADDR_DIAG_6_7);
    endfunction : is_diag

    // true when the frame addresses the command register
    function automatic logic is_cmd(input logic bank, input reg_addr_t addr);
        is_cmd = (bank == BANK_COMMAND) && (addr == ADDR_COMMAND);
    endfunction : is_cmd

    // channel number of the low channel of a pair; the high one is this plus one
    function automatic logic [2:0] pair_low(input logic [1:0] pair);
        pair_low = {pair, 1'b0};
    endfunction : pair_low

    // pack one channel pair into a diagnosis word
    function automatic reg_data_t pack_pair(input chan_t fault, input chan_t open, input logic [1:0] pair);
        reg_data_t w;
        w = '0;
        w[LOW_FAULT_BIT]  = fault[pair_low(pair)];
        w[LOW_OPEN_BIT]   = open[pair_low(pair)];
        w[HIGH_FAULT_BIT] = fault[pair_low(pair) | 3'h1];
        w[HIGH_OPEN_BIT]  = open[pair_low(pair) | 3'h1];
        pack_pair = w;
    endfunction : pack_pair

    // overload persistence timers
    // they share the clock enable, so a frozen block also freezes
    // the shutdown delay instead of letting it run on unseen
    ovl_shutdown_timer i_ovl_shutdown_timer
    (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .ovl    (ovl.timer)
    );

    // drive the timer side of the carrier
    assign ovl.clk_en   = clk_en_i;
    assign ovl.overload = overload_i;

    // frame decode
    // purely combinational; nothing is taken unless the state
    // register below is enabled by clk_en_i on the same edge
    always_comb
    begin
        pair_sel  = reg_addr_i;
        diag_read = reg_valid_i && !reg_write_i && is_diag(reg_bank_i, reg_addr_i);
        cmd_read  = reg_valid_i && !reg_write_i && is_cmd(reg_bank_i, reg_addr_i);
        // writes into the diagnosis bank are not decoded at all
        cmd_write = reg_valid_i && reg_write_i && is_cmd(reg_bank_i, reg_addr_i);
        clear_req = cmd_write && reg_wdata_i[CMD_CLEAR_BIT];
    end

    // flag events and the open-load flags hit by a read
    // overload_i passes the persistence timers first, so short
    // inrush spikes on a switching load do not latch a fault
    always_comb
    begin
        // overtemperature at once, overload after the persistence delay
        fault_set = overtemp_i | ovl.tripped;
        // open load only counts while the channel is actually off
        open_set  = open_load_i & ~channel_enable_o;
        open_clr  = '0;
        if (diag_read)
        begin
            // both channels of the read pair lose their open-load latch
            open_clr[pair_low(pair_sel)]        = 1'b1;
            open_clr[pair_low(pair_sel) | 3'h1] = 1'b1;
        end
    end

    // next-state logic
    always_comb
    begin
        state_next = state_reg;

        // a clear that swallowed a fault raised in the same frame would
        // let a shorted channel restart unnoticed, hence set wins
        // fault latches: a new event wins over a clear in the same cycle
        if (clear_req)
        begin
            state_next.fault = fault_set;
        end
        else
        begin
            state_next.fault = state_reg.fault | fault_set;
        end

        // a read must not hide an open load that appears while it is taken
        // open-load latches: set wins over the clear on read
        state_next.open = (state_reg.open & ~open_clr) | open_set;

        // command register
        // reset, standby and wake are only requested here; acting on
        // them is left to the power control logic outside this block
        if (cmd_write)
        begin
            // all four bits are loaded from the write data; the clear bit then self-clears
            state_next.cmd = reg_wdata_i;
        end
        else if (reg_valid_i)
        begin
            // clear_fault_latches drops with the next valid frame
            state_next.cmd[CMD_CLEAR_BIT] = 1'b0;
        end

        // the host sees the flags as they stood before this frame
        // read data captured before the read-side clear takes effect
        if (diag_read)
        begin
            state_next.rdata = pack_pair(state_reg.fault, state_reg.open, pair_sel);
        end
        else if (cmd_read)
        begin
            // command register reads back as written
            state_next.rdata = state_reg.cmd;
        end
        else if (reg_valid_i && !reg_write_i)
        begin
            // unmapped read returns zero
            state_next.rdata = RDATA_RESET_VALUE;
        end
    end

    // state register, frozen while the clock enable is low
    // reset loads every field from its package constant
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_reg.fault <= FLAGS_RESET_VALUE;
            state_reg.open  <= FLAGS_RESET_VALUE;
            state_reg.cmd   <= CMD_RESET_VALUE;
            state_reg.rdata <= RDATA_RESET_VALUE;
        end
        else if (clk_en_i)
        begin
            state_reg <= state_next;
        end
    end

    // outputs
    // the drive gate is combinational, so a latch that sets cuts the
    // channel in the same cycle rather than one cycle later
    always_comb
    begin
        // a latched fault keeps the channel off until the latch is cleared
        channel_enable_o     = channel_on_i & ~state_reg.fault;
        channel_fault_flag_o = state_reg.fault;
        open_load_flag_o     = state_reg.open;
        reg_rdata_o          = state_reg.rdata;
        soft_reset_req_o     = state_reg.cmd[CMD_RESET_BIT];
        standby_request_o    = state_reg.cmd[CMD_STANDBY_BIT];
        wake_request_o       = state_reg.cmd[CMD_WAKE_BIT];
    end

endmodule : relay_diag_status_regs

/* dv/relay_diag_monitor.sv */
// port checker for the relay diagnosis register block
// assumes one clock domain, asynchronous active-low reset
`timescale 1ns/1ps
module relay_diag_monitor
    import relay_diag_pkg::*;
(
    input wire logic       clk_i,                 // device clock
    input wire logic       rstn_i,                // asynchronous reset, active low
    input wire logic       clk_en_i,              // clock enable
    input wire logic       reg_valid_i,           // frame strobe
    input wire logic       reg_write_i,           // frame is a write
    input wire logic       reg_bank_i,            // register_bank_selector
    input wire reg_addr_t  reg_addr_i,            // address in the bank
    input wire reg_data_t  reg_wdata_i,           // write data
    input wire logic [3:0] reg_rdata_o,           // read data
    input wire chan_t      channel_on_i,          // requested channel state
    input wire chan_t      overload_i,            // overload detectors
    input wire chan_t      overtemp_i,            // overtemperature detectors
    input wire chan_t      open_load_i,           // open load detectors
    input wire chan_t      channel_enable_o,      // gated channel drive
    input wire chan_t      channel_fault_flag_o,  // fault latches
    input wire chan_t      open_load_flag_o,      // open-load latches
    input wire logic       soft_reset_req_o,      // command bit 1
    input wire logic       standby_request_o,     // command bit 2
    input wire logic       wake_request_o         // command bit 3
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // taken command writes and diagnosis reads
    wire logic cmd_wr = clk_en_i & reg_valid_i & reg_write_i & (reg_bank_i == BANK_COMMAND) & (reg_addr_i == ADDR_COMMAND);
    wire logic diag_rd = clk_en_i & reg_valid_i & ~reg_write_i & (reg_bank_i == BANK_DIAG);
    wire logic [2:0] lo = {reg_addr_i, 1'b0};  // low channel of the addressed pair
    wire logic [3:0] diag_word = {open_load_flag_o[lo+1], channel_fault_flag_o[lo+1],
                                  open_load_flag_o[lo], channel_fault_flag_o[lo]};
    wire chan_t pair = chan_t'(8'h03 << lo);  // channels of the addressed pair
    wire logic [2:0] cmd_out = {wake_request_o, standby_request_o, soft_reset_req_o};

    a_enable_gate: assert property (channel_enable_o == (channel_on_i & ~channel_fault_flag_o))
        else $error("channel drive not gated by fault latch");
    a_overtemp_latch: assert property (clk_en_i |=> (channel_fault_flag_o & $past(overtemp_i)) == $past(overtemp_i))
        else $error("overtemperature did not latch fault");
    a_open_latch: assert property (clk_en_i |=> (open_load_flag_o & $past(open_load_i & ~channel_enable_o))
                                   == $past(open_load_i & ~channel_enable_o))
        else $error("off-state open load did not latch");
    a_fault_keep: assert property (!(cmd_wr && reg_wdata_i[CMD_CLEAR_BIT]) |=>
        (channel_fault_flag_o & $past(channel_fault_flag_o)) == $past(channel_fault_flag_o))
        else $error("fault flag lost without clear command");
    a_fault_cause: assert property (clk_en_i |=> (channel_fault_flag_o & ~$past(channel_fault_flag_o)
                                    & ~$past(overtemp_i | overload_i)) == '0)
        else $error("fault flag set without cause");
    a_clear_all: assert property (cmd_wr && reg_wdata_i[CMD_CLEAR_BIT] && overtemp_i == '0
                                  && overload_i == '0 |=> channel_fault_flag_o == '0)
        else $error("clear command left fault flags");
    a_cmd_load: assert property (cmd_wr |=> cmd_out == $past(reg_wdata_i[3:1]))
        else $error("command bits not loaded");
    a_cmd_hold: assert property (!cmd_wr |=> $stable(cmd_out))
        else $error("command bits changed without write");
    a_diag_word: assert property (diag_rd |=> reg_rdata_o == $past(diag_word))
        else $error("diagnosis read word wrong");
    a_read_clear: assert property (diag_rd && open_load_i == '0 |=> (open_load_flag_o & $past(pair)) == '0)
        else $error("read did not clear open-load flags");
endmodule : relay_diag_monitor

bind relay_diag_status_regs relay_diag_monitor i_relay_diag_monitor (.clk_i, .rstn_i, .clk_en_i, .reg_valid_i,
    .reg_write_i, .reg_bank_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .channel_on_i, .overload_i, .overtemp_i,
    .open_load_i, .channel_enable_o, .channel_fault_flag_o, .open_load_flag_o, .soft_reset_req_o,
    .standby_request_o, .wake_request_o);

/* dv/host_frame_model.sv */
// host side model: issues one register frame at a time
// assumes frames are taken at the rising edge with clock enable high
`timescale 1ns/1ps
module host_frame_model
    import relay_diag_pkg::*;
(
    input  wire logic clk_i,    // device clock
    output logic      valid_o,  // frame strobe
    output logic      write_o,  // frame is a write
    output logic      bank_o,   // register_bank_selector
    output reg_addr_t addr_o,   // address in the bank
    output reg_data_t wdata_o   // write data
);
    initial {valid_o, write_o, bank_o, addr_o, wdata_o} = '0;
    // drive after a falling edge, hold across the taking edge, then release
    task automatic frame(input logic wr, input logic bk, input reg_addr_t ad, input reg_data_t wd);
        @(negedge clk_i);
        {valid_o, write_o, bank_o, addr_o, wdata_o} = {1'b1, wr, bk, ad, wd};
        @(negedge clk_i);
        valid_o = 1'b0;
        {write_o, bank_o, addr_o, wdata_o} = ~{wr, bk, ad, wd};  // released lines do not keep the old value
        @(negedge clk_i);
    endtask : frame
endmodule : host_frame_model

/* dv/relay_diag_status_regs_tb_top.sv */
// self-checking bench for the relay diagnosis register block
// assumes a 50 MHz clock and the frame-level host model
`timescale 1ns/1ps
module relay_diag_status_regs_tb_top;
    import relay_diag_pkg::*;
    logic clk_i = 1'b0, rstn_i = 1'b0, clk_en = 1'b1;
    logic valid, write, bank, rst_req, stb_req, wake_req;
    reg_addr_t addr;
    reg_data_t wdata;
    logic [3:0] rdata;
    chan_t ch_on = '1, ovl = '0, otp = '0, opn = '0, en, fault, open;
    int n_errors = 0, comparisons = 0;
    always #10 clk_i = ~clk_i;

    host_frame_model i_host_frame_model (.clk_i(clk_i), .valid_o(valid), .write_o(write), .bank_o(bank),
        .addr_o(addr), .wdata_o(wdata));
    relay_diag_status_regs i_relay_diag_status_regs (.clk_i(clk_i), .rstn_i(rstn_i), .clk_en_i(clk_en),
        .reg_valid_i(valid), .reg_write_i(write), .reg_bank_i(bank), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .channel_on_i(ch_on), .overload_i(ovl), .overtemp_i(otp), .open_load_i(opn),
        .channel_enable_o(en), .channel_fault_flag_o(fault), .open_load_flag_o(open),
        .soft_reset_req_o(rst_req), .standby_request_o(stb_req), .wake_request_o(wake_req));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        if (n_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish

    // frozen clock enable, overtemperature latch, read-only diagnosis, clear
    task automatic test_overtemp();
        @(negedge clk_i);
        clk_en = 1'b0;
        otp = 8'h20;
        repeat (3) @(negedge clk_i);
        check(fault, 8'h00);
        clk_en = 1'b1;
        @(negedge clk_i);
        otp = 8'h00;
        check(fault, 8'h20);
        check(en, 8'hdf);
        i_host_frame_model.frame(1'b0, BANK_DIAG, ADDR_DIAG_4_5, 4'h0);
        check(rdata, 8'h04);
        i_host_frame_model.frame(1'b1, BANK_DIAG, ADDR_DIAG_4_5, 4'hf);
        i_host_frame_model.frame(1'b1, BANK_DIAG, ADDR_DIAG_0_1, 4'h1);
        check(fault, 8'h20);
        for (int a = 1; a < 4; a++)
        begin
            i_host_frame_model.frame(1'b0, BANK_COMMAND, reg_addr_t'(a), 4'h0);
            check(rdata, 8'h00);
        end
        i_host_frame_model.frame(1'b1, BANK_COMMAND, ADDR_COMMAND, 4'h1);
        check(fault, 8'h00);
        check(en, 8'hff);
        i_host_frame_model.frame(1'b0, BANK_COMMAND, ADDR_COMMAND, 4'h0);
        check(rdata, 8'h01);
        i_host_frame_model.frame(1'b0, BANK_COMMAND, ADDR_COMMAND, 4'h0);
        check(rdata, 8'h00);
    endtask : test_overtemp

    // each of the reset, standby and wake bits written alone, seen on its output and read back
    task automatic test_command();
        for (int b = 1; b < 4; b++)
        begin
            i_host_frame_model.frame(1'b1, BANK_COMMAND, ADDR_COMMAND, reg_data_t'(1 << b));
            check({wake_req, stb_req, rst_req}, 8'(1 << (b - 1)));
            i_host_frame_model.frame(1'b0, BANK_COMMAND, ADDR_COMMAND, 4'h0);
            check(rdata, 8'(1 << b));
        end
        i_host_frame_model.frame(1'b1, BANK_COMMAND, ADDR_COMMAND, 4'h0);
        check({wake_req, stb_req, rst_req}, 8'h00);
    endtask : test_command

    // open load latches only on an off channel and clears on read
    task automatic test_open_load();
        ch_on = 8'hfb;
        opn = 8'h0c;
        @(negedge clk_i);
        opn = 8'h00;
        check(open, 8'h04);
        i_host_frame_model.frame(1'b0, BANK_DIAG, ADDR_DIAG_2_3, 4'h0);
        check(rdata, 8'h02);
        check(open, 8'h00);
        ch_on = 8'hff;
    endtask : test_open_load

    // persistent overload turns channel off at the end of the delay
    task automatic test_overload();
        ovl = 8'h01;
        repeat (OVL_OFF_CYCLES - 1) @(negedge clk_i);
        check(fault, 8'h00);
        check(en, 8'hff);
        @(negedge clk_i);
        check(fault, 8'h01);
        check(en, 8'hfe);
        i_host_frame_model.frame(1'b1, BANK_COMMAND, ADDR_COMMAND, 4'h1);
        check(fault, 8'h01);
        ovl = 8'h00;
        i_host_frame_model.frame(1'b0, BANK_DIAG, ADDR_DIAG_0_1, 4'h0);
        check(rdata, 8'h01);
        i_host_frame_model.frame(1'b1, BANK_COMMAND, ADDR_COMMAND, 4'h1);
        check(fault, 8'h00);
    endtask : test_overload

    // values right after reset, then every diagnosis address read back
    task automatic test_reset_values();
        check(fault, 8'h00);
        check(open, 8'h00);
        check(en, 8'hff);
        check({wake_req, stb_req, rst_req}, 8'h00);
        for (int a = 0; a < 4; a++)
        begin
            i_host_frame_model.frame(1'b0, BANK_DIAG, reg_addr_t'(a), 4'h0);
            check(rdata, 8'h00);
        end
    endtask : test_reset_values

    // main sequence: reset, reset values, scenarios
    initial
    begin
        repeat (8) @(negedge clk_i);
        rstn_i = 1'b1;
        test_reset_values();
        test_overtemp();
        test_command();
        test_open_load();
        test_overload();
        tally_and_finish();
    end

    // watchdog well beyond the expected run of about 3100 cycles
    initial
    begin
        #400000;
        n_errors++;
        tally_and_finish();
    end
endmodule : relay_diag_status_regs_tb_top
